// ### shared/pesd_pkg.sv
// Purpose: constants, types and event codes shared by the event select decoder.
// Assumes: one core clock, all pipeline status arrives on that clock.
// Notes:   event and unit mask codes are the programmed selection values.
package pesd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int unsigned PESD_SLOTS        = 4;
    localparam int unsigned PESD_ADDR_W       = 48;
    localparam int unsigned PESD_CNT_W        = 3;
    localparam int unsigned PESD_NUM_COUNTERS = 2;
    localparam int unsigned PESD_PRECISE_CTR  = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Event numbers and unit masks
    localparam logic [7:0] PESD_EV_LOAD_RETIRED = 8'hCB;
    localparam logic [7:0] PESD_UM_XLAT_MISS    = 8'h10;
    localparam logic [7:0] PESD_EV_FP_TRANS     = 8'hCC;
    localparam logic [7:0] PESD_UM_TO_PACKED    = 8'h01;
    localparam logic [7:0] PESD_UM_TO_FLOAT     = 8'h02;
    localparam logic [7:0] PESD_EV_ASSIST       = 8'hCD;
    localparam logic [7:0] PESD_EV_VEC_RETIRED  = 8'hCE;
    localparam logic [7:0] PESD_EV_SAT_RETIRED  = 8'hCF;
    localparam logic [7:0] PESD_UM_NONE         = 8'h00;
    localparam logic [7:0] PESD_EV_ALIAS_STALL  = 8'hD2;
    localparam logic [7:0] PESD_UM_READPORT     = 8'h01;
    localparam logic [7:0] PESD_UM_PARTIAL_REG  = 8'h02;
    localparam logic [7:0] PESD_UM_FLAG         = 8'h04;
    localparam logic [7:0] PESD_UM_FP_STATUS    = 8'h08;
    localparam logic [7:0] PESD_UM_STALL_ANY    = 8'h0F;

    ////////////////////////////////////////////////////////////////////////////
    // Increment weights and reset values
    localparam logic [PESD_CNT_W-1:0] PESD_CNT_ZERO     = 3'h0;
    localparam logic [PESD_CNT_W-1:0] PESD_CNT_ONE      = 3'h1;
    localparam logic [PESD_CNT_W-1:0] PESD_FP_STATUS_WORD_WEIGHT  = 3'h2;
    localparam logic [1:0]            PESD_RST_SYNC_RST = 2'h0;

    typedef enum logic [1:0] {
        PESD_MODE_NONE   = 2'b00,
        PESD_MODE_FLOAT  = 2'b01,
        PESD_MODE_PACKED = 2'b10
    } pesd_mode_t;

    // One retirement slot, slot 0 oldest
    typedef struct packed {
        logic                   valid;
        logic                   uses_packed_int;
        logic                   uses_float;
        logic                   state_clear;
        logic                   saturating;
        logic                   is_load;
        logic                   xlat_miss;
        logic                   faulted;
        logic                   cacheable;
        logic                   sw_prefetch;
        logic [PESD_ADDR_W-1:0] addr;
    } pesd_slot_t;

    typedef struct packed {
        logic readport;
        logic partial_reg;
        logic flag;
        logic fp_status_write;
    } pesd_stall_t;

    typedef struct packed {
        logic       enable;
        logic [7:0] event_num;
        logic [7:0] umask;
    } pesd_sel_t;

    typedef struct packed {
        logic [PESD_CNT_W-1:0] xlat_miss;
        logic [PESD_CNT_W-1:0] to_packed;
        logic [PESD_CNT_W-1:0] to_float;
        logic [PESD_CNT_W-1:0] assist;
        logic [PESD_CNT_W-1:0] vec_retired;
        logic [PESD_CNT_W-1:0] sat_retired;
        logic [PESD_CNT_W-1:0] readport;
        logic [PESD_CNT_W-1:0] partial_reg;
        logic [PESD_CNT_W-1:0] flag;
        logic [PESD_CNT_W-1:0] fp_status;
        logic [PESD_CNT_W-1:0] stall_any;
    } pesd_counts_t;

endpackage

// ### src/pesd_event_match.sv
// Purpose: compare one counter's selection with the cycle's event counts.
// Assumes: counts are computed on the same clock; purely combinational.
// Notes:   an unknown selection or a disabled counter yields zero.
`timescale 1ns/1ns
module pesd_event_match #(
    parameter int unsigned COUNTER_IDX = 0
) (
    input  wire pesd_pkg::pesd_sel_t              sel,
    input  wire pesd_pkg::pesd_counts_t           counts,
    output logic [pesd_pkg::PESD_CNT_W-1:0]       inc
);
    import pesd_pkg::*;

    always_comb begin
        inc = PESD_CNT_ZERO;
        if (sel.enable) begin
            unique case (sel.event_num)
                PESD_EV_LOAD_RETIRED: begin
                    // Other counters ignore this event entirely
                    if (sel.umask == PESD_UM_XLAT_MISS && COUNTER_IDX == PESD_PRECISE_CTR) begin
                        inc = counts.xlat_miss;
                    end
                end
                PESD_EV_FP_TRANS: begin
                    if (sel.umask == PESD_UM_TO_PACKED) begin
                        inc = counts.to_packed;
                    end else if (sel.umask == PESD_UM_TO_FLOAT) begin
                        inc = counts.to_float;
                    end
                end
                PESD_EV_ASSIST: begin
                    if (sel.umask == PESD_UM_NONE) begin
                        inc = counts.assist;
                    end
                end
                PESD_EV_VEC_RETIRED: begin
                    if (sel.umask == PESD_UM_NONE) begin
                        inc = counts.vec_retired;
                    end
                end
                PESD_EV_SAT_RETIRED: begin
                    if (sel.umask == PESD_UM_NONE) begin
                        inc = counts.sat_retired;
                    end
                end
                PESD_EV_ALIAS_STALL: begin
                    unique case (sel.umask)
                        PESD_UM_READPORT:    inc = counts.readport;
                        PESD_UM_PARTIAL_REG: inc = counts.partial_reg;
                        PESD_UM_FLAG:        inc = counts.flag;
                        PESD_UM_FP_STATUS:   inc = counts.fp_status;
                        PESD_UM_STALL_ANY:   inc = counts.stall_any;
                        default:             inc = PESD_CNT_ZERO;
                    endcase
                end
                default: inc = PESD_CNT_ZERO;
            endcase
        end
    end

endmodule

// ### src/pesd_precise_sampler.sv
// Purpose: capture the address of the instruction retiring after a sampled load.
// Assumes: slot 0 is the oldest; trigger bits are already qualified.
// Notes:   one sample per cycle; triggers while a sample is in flight are dropped.
`timescale 1ns/1ns
module pesd_precise_sampler (
    input  wire                                 sys_clk,
    input  wire                                 rst_n,
    input  wire                                 enable,
    input  wire [pesd_pkg::PESD_SLOTS-1:0]      trigger,
    input  wire pesd_pkg::pesd_slot_t           slot [pesd_pkg::PESD_SLOTS],
    output logic                                sample_valid,
    output logic [pesd_pkg::PESD_ADDR_W-1:0]    sample_addr
);
    import pesd_pkg::*;

    typedef struct packed {
        logic                   pending;
        logic                   valid;
        logic [PESD_ADDR_W-1:0] addr;
    } pesd_samp_state_t;

    pesd_samp_state_t st_q;
    pesd_samp_state_t st_d;
    logic             waiting;
    logic             captured;

    always_comb begin
        st_d     = st_q;
        st_d.valid = 1'b0;
        waiting  = st_q.pending;
        captured = 1'b0;
        // Walk in program order so the next instruction is the younger slot
        for (int s = 0; s < PESD_SLOTS; s++) begin
            // Disarmed capture would move the address with no pulse
            if (slot[s].valid && waiting && !captured && enable) begin
                st_d.addr  = slot[s].addr;
                st_d.valid = 1'b1;
                waiting    = 1'b0;
                captured   = 1'b1;
            end
            if (trigger[s] && !waiting && !captured) begin
                waiting = 1'b1;
            end
        end
        st_d.pending = waiting && enable;
        if (!enable) begin
            st_d.valid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sample_valid = st_q.valid;
    assign sample_addr  = st_q.addr;

endmodule

// ### src/pesd_event_select.sv
// Purpose: detect countable pipeline conditions and steer them to counters.
// Assumes: retirement slots and stall flags are driven on sys_clk.
// Notes:   increments appear one cycle after the conditions that cause them.
`timescale 1ns/1ns
module pesd_event_select #(
    parameter int unsigned NUM_COUNTERS = pesd_pkg::PESD_NUM_COUNTERS
) (
    input  wire                                 sys_clk,
    input  wire                                 reset_n,
    input  wire pesd_pkg::pesd_slot_t           retire_slot [pesd_pkg::PESD_SLOTS],
    input  wire pesd_pkg::pesd_stall_t          alias_stall,
    input  wire pesd_pkg::pesd_sel_t            counter_sel [NUM_COUNTERS],
    input  wire                                 precise_enable,
    output logic [pesd_pkg::PESD_CNT_W-1:0]     counter_inc [NUM_COUNTERS],
    output logic                                sample_valid,
    output logic [pesd_pkg::PESD_ADDR_W-1:0]    sample_addr
);
    import pesd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        pesd_mode_t                           mode;
        logic [NUM_COUNTERS-1:0][PESD_CNT_W-1:0] inc;
    } pesd_state_t;

    pesd_state_t     state_q;
    pesd_state_t     state_d;
    logic [1:0]      rst_sync_q;
    logic            rst_n;

    logic [PESD_SLOTS-1:0] load_qual;
    logic [PESD_SLOTS-1:0] vec_hit;
    logic [PESD_SLOTS-1:0] sat_hit;
    logic [PESD_SLOTS-1:0] packed_hit;
    logic [PESD_SLOTS-1:0] float_hit;
    logic [PESD_SLOTS-1:0] clear_hit;
    logic [PESD_SLOTS-1:0] sample_trigger;

    pesd_counts_t    counts_c;
    pesd_mode_t      mode_c;
    logic [PESD_CNT_W-1:0] match_inc [NUM_COUNTERS];
    logic            sampling_armed;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    // Asynchronous assert, release two edges later to avoid metastable release
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= PESD_RST_SYNC_RST;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Per-slot qualification

    for (genvar s = 0; s < PESD_SLOTS; s++) begin : g_slot
        // Faulting loads never reach the count, even if they missed
        assign load_qual[s] = retire_slot[s].valid
                            && retire_slot[s].is_load
                            && retire_slot[s].xlat_miss
                            && !retire_slot[s].faulted
                            && retire_slot[s].cacheable
                            && !retire_slot[s].sw_prefetch;

        assign vec_hit[s]    = retire_slot[s].valid && retire_slot[s].uses_packed_int;
        assign sat_hit[s]    = retire_slot[s].valid && retire_slot[s].uses_packed_int
                             && retire_slot[s].saturating;
        assign packed_hit[s] = retire_slot[s].valid && retire_slot[s].uses_packed_int;
        assign float_hit[s]  = retire_slot[s].valid && retire_slot[s].uses_float
                             && !retire_slot[s].uses_packed_int;
        assign clear_hit[s]  = retire_slot[s].valid && retire_slot[s].state_clear;

        assign sample_trigger[s] = load_qual[s] && sampling_armed;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event counting for this cycle

    always_comb begin
        counts_c = '0;
        mode_c   = state_q.mode;

        // Slots walked oldest first: a transition depends on program order
        for (int s = 0; s < PESD_SLOTS; s++) begin
            if (load_qual[s]) begin
                counts_c.xlat_miss = counts_c.xlat_miss + PESD_CNT_ONE;
            end
            if (vec_hit[s]) begin
                counts_c.vec_retired = counts_c.vec_retired + PESD_CNT_ONE;
            end
            if (sat_hit[s]) begin
                counts_c.sat_retired = counts_c.sat_retired + PESD_CNT_ONE;
            end
            // Assist only when the clear really changes packed state
            if (clear_hit[s] && mode_c == PESD_MODE_PACKED) begin
                counts_c.assist = counts_c.assist + PESD_CNT_ONE;
            end
            unique case (mode_c)
                PESD_MODE_NONE: begin
                    if (packed_hit[s]) begin
                        mode_c = PESD_MODE_PACKED;
                    end else if (float_hit[s]) begin
                        mode_c = PESD_MODE_FLOAT;
                    end
                end
                PESD_MODE_FLOAT: begin
                    if (packed_hit[s]) begin
                        counts_c.to_packed = counts_c.to_packed + PESD_CNT_ONE;
                        mode_c             = PESD_MODE_PACKED;
                    end
                end
                PESD_MODE_PACKED: begin
                    if (float_hit[s]) begin
                        counts_c.to_float = counts_c.to_float + PESD_CNT_ONE;
                        mode_c            = PESD_MODE_FLOAT;
                    end
                end
                default: begin
                    mode_c = PESD_MODE_NONE;
                end
            endcase
        end

        // Level per cycle, so a stall that repeats on retry counts again
        if (alias_stall.readport) begin
            counts_c.readport = PESD_CNT_ONE;
        end
        if (alias_stall.partial_reg) begin
            counts_c.partial_reg = PESD_CNT_ONE;
        end
        if (alias_stall.flag) begin
            counts_c.flag = PESD_CNT_ONE;
        end
        if (alias_stall.fp_status_write) begin
            counts_c.fp_status = PESD_FP_STATUS_WORD_WEIGHT;
        end
        // Overlapping stalls are one lost cycle, not several
        if (alias_stall.readport || alias_stall.partial_reg
            || alias_stall.flag || alias_stall.fp_status_write) begin
            counts_c.stall_any = PESD_CNT_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Selection per counter

    for (genvar c = 0; c < NUM_COUNTERS; c++) begin : g_ctr
        pesd_event_match #(
            .COUNTER_IDX (c)
        ) u_match (
            .sel    (counter_sel[c]),
            .counts (counts_c),
            .inc    (match_inc[c])
        );
        assign counter_inc[c] = state_q.inc[c];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Precise sampling on the counter-zero load event

    // Sampling follows only the one counter allowed to carry this event
    assign sampling_armed = precise_enable
                          && counter_sel[PESD_PRECISE_CTR].enable
                          && counter_sel[PESD_PRECISE_CTR].event_num == PESD_EV_LOAD_RETIRED
                          && counter_sel[PESD_PRECISE_CTR].umask == PESD_UM_XLAT_MISS;

    pesd_precise_sampler u_sampler (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .enable       (sampling_armed),
        .trigger      (sample_trigger),
        .slot         (retire_slot),
        .sample_valid (sample_valid),
        .sample_addr  (sample_addr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_comb begin
        state_d      = state_q;
        state_d.mode = mode_c;
        for (int c = 0; c < NUM_COUNTERS; c++) begin
            state_d.inc[c] = match_inc[c];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

endmodule

// ### testbench/pesd_event_select_checker.sv
// Purpose: port-level assertions for the event select decoder.
// Assumes: selections are set at least three edges after reset release.
// Notes:   increments lag their causes by exactly one cycle.
`timescale 1ns/1ns
module pesd_event_select_checker #(
    parameter int unsigned NUM_COUNTERS = 2
) (
    input wire                              sys_clk,
    input wire                              reset_n,
    input wire pesd_pkg::pesd_slot_t        retire_slot [pesd_pkg::PESD_SLOTS],
    input wire pesd_pkg::pesd_stall_t       alias_stall,
    input wire pesd_pkg::pesd_sel_t         counter_sel [NUM_COUNTERS],
    input wire                              precise_enable,
    input wire [pesd_pkg::PESD_CNT_W-1:0]   counter_inc [NUM_COUNTERS],
    input wire                              sample_valid,
    input wire [pesd_pkg::PESD_ADDR_W-1:0]  sample_addr
);
    import pesd_pkg::*;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    logic [2:0] vec_n;
    logic [2:0] sat_n;

    ////////////////////////////////////////////////////////////////////////////
    // Per-cycle reference counts over all slots
    always_comb begin
        vec_n = 3'h0;
        sat_n = 3'h0;
        for (int i = 0; i < PESD_SLOTS; i++) begin
            vec_n = vec_n + 3'(retire_slot[i].valid & retire_slot[i].uses_packed_int);
            sat_n = sat_n + 3'(retire_slot[i].valid & retire_slot[i].uses_packed_int & retire_slot[i].saturating);
        end
    end

    function automatic logic is_sel(pesd_sel_t s, logic [7:0] e, logic [7:0] u);
        return s.enable && s.event_num == e && s.umask == u;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Properties
    property p_fp_status_word;
        is_sel(counter_sel[1], PESD_EV_ALIAS_STALL, PESD_UM_FP_STATUS) && alias_stall.fp_status_write
        |=> counter_inc[1] == PESD_FP_STATUS_WORD_WEIGHT;
    endproperty
    a_fp_status_word: assert property (p_fp_status_word) else $error("status write weight wrong");

    property p_any;
        is_sel(counter_sel[0], PESD_EV_ALIAS_STALL, PESD_UM_STALL_ANY)
        |=> counter_inc[0] == {2'h0, $past(|alias_stall)};
    endproperty
    a_any: assert property (p_any) else $error("combined stall count wrong");

    property p_readport;
        is_sel(counter_sel[1], PESD_EV_ALIAS_STALL, PESD_UM_READPORT)
        |=> counter_inc[1] == {2'h0, $past(alias_stall.readport)};
    endproperty
    a_readport: assert property (p_readport) else $error("read port stall count wrong");

    property p_flag;
        is_sel(counter_sel[1], PESD_EV_ALIAS_STALL, PESD_UM_FLAG)
        |=> counter_inc[1] == {2'h0, $past(alias_stall.flag)};
    endproperty
    a_flag: assert property (p_flag) else $error("flag stall count wrong");

    property p_off;
        !counter_sel[1].enable |=> counter_inc[1] == PESD_CNT_ZERO;
    endproperty
    a_off: assert property (p_off) else $error("disabled counter moved");

    property p_ctr_one_load;
        is_sel(counter_sel[1], PESD_EV_LOAD_RETIRED, PESD_UM_XLAT_MISS) |=> counter_inc[1] == PESD_CNT_ZERO;
    endproperty
    a_ctr_one_load: assert property (p_ctr_one_load) else $error("load event on counter one");

    property p_vec;
        is_sel(counter_sel[0], PESD_EV_VEC_RETIRED, PESD_UM_NONE) |=> counter_inc[0] == $past(vec_n);
    endproperty
    a_vec: assert property (p_vec) else $error("vector retire count wrong");

    property p_sat;
        is_sel(counter_sel[1], PESD_EV_SAT_RETIRED, PESD_UM_NONE) |=> counter_inc[1] == $past(sat_n);
    endproperty
    a_sat: assert property (p_sat) else $error("saturating retire count wrong");

    property p_hold;
        !sample_valid |-> $stable(sample_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("sample address moved without pulse");

    property p_arm;
        sample_valid |-> $past(precise_enable);
    endproperty
    a_arm: assert property (p_arm) else $error("sample without enable");

    c_fp_status_word: cover property (is_sel(counter_sel[1], PESD_EV_ALIAS_STALL, PESD_UM_FP_STATUS)
                            && alias_stall.fp_status_write);
    c_sample: cover property (sample_valid);
    c_load: cover property (is_sel(counter_sel[0], PESD_EV_LOAD_RETIRED, PESD_UM_XLAT_MISS)
                            && counter_inc[0] != 3'h0);
endmodule

bind pesd_event_select pesd_event_select_checker #(.NUM_COUNTERS(NUM_COUNTERS)) chk_u (
    .sys_clk        (sys_clk),
    .reset_n        (reset_n),
    .retire_slot    (retire_slot),
    .alias_stall    (alias_stall),
    .counter_sel    (counter_sel),
    .precise_enable (precise_enable),
    .counter_inc    (counter_inc),
    .sample_valid   (sample_valid),
    .sample_addr    (sample_addr)
);

// ### testbench/pesd_pipe_model.sv
// Purpose: retirement and rename stage stand-in feeding the decoder.
// Assumes: requests change only at the falling clock edge.
// Notes:   an empty slot shows scrambled fields so stale values never count.
`timescale 1ns/1ns
module pesd_pipe_model (
    input wire  pesd_pkg::pesd_slot_t   slot_req [pesd_pkg::PESD_SLOTS],
    input wire  pesd_pkg::pesd_stall_t  stall_req,
    output      pesd_pkg::pesd_slot_t   retire_slot [pesd_pkg::PESD_SLOTS],
    output      pesd_pkg::pesd_stall_t  alias_stall
);
    import pesd_pkg::*;

    always_comb begin
        alias_stall = stall_req;
        for (int i = 0; i < PESD_SLOTS; i++) begin
            retire_slot[i] = slot_req[i].valid ? slot_req[i]
                           : pesd_slot_t'({1'b0, ~slot_req[i][$bits(pesd_slot_t)-2:0]});
        end
    end
endmodule

// ### testbench/tb.sv
// Purpose: directed scenarios for the event select decoder.
// Assumes: outputs are read one falling edge after their inputs.
// Notes:   mode-dependent scenarios run first, from the reset mode.
`timescale 1ns/1ns
module tb;
    import pesd_pkg::*;

    localparam logic [9:0] F_V = 10'h200, F_PK = 10'h100, F_FL = 10'h080, F_SC = 10'h040;
    localparam logic [9:0] F_SAT = 10'h020, F_MS = 10'h008, F_FT = 10'h004, F_CA = 10'h002, F_PF = 10'h001;
    localparam logic [9:0] GOOD = 10'h21A;

    logic                   sys_clk = 1'b0;
    logic                   reset_n = 1'b0;
    logic                   precise_enable = 1'b0;
    pesd_slot_t             slot_req [PESD_SLOTS];
    pesd_stall_t            stall_req;
    pesd_sel_t              counter_sel [2];
    pesd_slot_t             retire_slot [PESD_SLOTS];
    pesd_stall_t            alias_stall;
    logic [PESD_CNT_W-1:0]  counter_inc [2];
    logic                   sample_valid;
    logic [PESD_ADDR_W-1:0] sample_addr;
    int                     errors = 0;
    int                     samples_checked = 0;

    always #5 sys_clk = ~sys_clk;

    pesd_pipe_model pipe_u (.slot_req(slot_req), .stall_req(stall_req), .retire_slot(retire_slot),
                            .alias_stall(alias_stall));

    pesd_event_select #(.NUM_COUNTERS(2)) dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .retire_slot(retire_slot), .alias_stall(alias_stall),
        .counter_sel(counter_sel), .precise_enable(precise_enable), .counter_inc(counter_inc),
        .sample_valid(sample_valid), .sample_addr(sample_addr));

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic set(input int i, input logic [9:0] f, input logic [47:0] a);
        slot_req[i] = pesd_slot_t'({f, a});
    endtask

    task automatic sel(input int c, input logic [7:0] e, input logic [7:0] u);
        counter_sel[c] = '{1'b1, e, u};
    endtask

    task automatic idle();
        for (int i = 0; i < PESD_SLOTS; i++) begin
            slot_req[i] = '0;
        end
        stall_req = '0;
    endtask

    // Inputs were set at a falling edge; the next one sees the registered answer
    task automatic beat();
        @(negedge sys_clk);
    endtask

    task automatic print_verdict();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_trans();
        sel(0, PESD_EV_FP_TRANS, PESD_UM_TO_PACKED);
        sel(1, PESD_EV_FP_TRANS, PESD_UM_TO_FLOAT);
        set(0, F_V | F_FL, 48'h0);
        beat();
        chk(counter_inc[0], 3'h0);
        set(0, F_V | F_PK, 48'h0);
        set(1, F_V | F_PK, 48'h0);
        set(2, F_V | F_FL, 48'h0);
        set(3, F_V | F_PK, 48'h0);
        beat();
        chk(counter_inc[0], 3'h2);
        chk(counter_inc[1], 3'h1);
        sel(0, PESD_EV_ASSIST, PESD_UM_NONE);
        set(0, F_V | F_SC, 48'h0);
        set(1, F_V | F_FL, 48'h0);
        set(2, F_V | F_SC, 48'h0);
        set(3, F_SC, 48'h0);
        beat();
        chk(counter_inc[0], 3'h1);
        chk(counter_inc[1], 3'h1);
        idle();
    endtask

    task automatic t_alias();
        logic [7:0] um;
        for (int b = 0; b < 4; b++) begin
            um = 8'h01 << b;
            for (int s = 0; s < 16; s++) begin
                sel(0, PESD_EV_ALIAS_STALL, PESD_UM_STALL_ANY);
                sel(1, PESD_EV_ALIAS_STALL, um);
                stall_req = pesd_stall_t'(s[3:0]);
                beat();
                chk(counter_inc[0], {2'h0, s != 0});
                chk(counter_inc[1], s[3-b] ? (b == 3 ? 3'h2 : 3'h1) : 3'h0);
            end
        end
        idle();
    endtask

    task automatic t_retire();
        sel(0, PESD_EV_VEC_RETIRED, PESD_UM_NONE);
        sel(1, PESD_EV_SAT_RETIRED, PESD_UM_NONE);
        set(0, F_V | F_PK, 48'h1);
        set(1, F_V | F_PK | F_SAT, 48'h2);
        set(2, F_PK | F_SAT, 48'h3);
        set(3, F_V | F_FL | F_SAT, 48'h4);
        beat();
        chk(counter_inc[0], 3'h2);
        chk(counter_inc[1], 3'h1);
        sel(0, PESD_EV_LOAD_RETIRED, PESD_UM_XLAT_MISS);
        sel(1, PESD_EV_LOAD_RETIRED, PESD_UM_XLAT_MISS);
        set(0, GOOD, 48'h0);
        set(1, GOOD | F_FT, 48'h0);
        set(2, GOOD & ~F_CA, 48'h0);
        set(3, GOOD | F_PF, 48'h0);
        beat();
        chk(counter_inc[0], 3'h1);
        chk(counter_inc[1], 3'h0);
        set(1, GOOD & ~F_V, 48'h0);
        set(2, GOOD, 48'h0);
        set(3, GOOD & ~F_MS, 48'h0);
        beat();
        chk(counter_inc[0], 3'h2);
        sel(0, PESD_EV_LOAD_RETIRED, 8'h20);
        counter_sel[1] = '{1'b0, PESD_EV_VEC_RETIRED, PESD_UM_NONE};
        set(0, F_V | F_PK, 48'h0);
        beat();
        chk(counter_inc[0], 3'h0);
        chk(counter_inc[1], 3'h0);
        idle();
    endtask

    task automatic t_precise();
        precise_enable = 1'b1;
        sel(0, PESD_EV_LOAD_RETIRED, PESD_UM_XLAT_MISS);
        set(0, GOOD, 48'h0);
        set(1, F_V, 48'hA5A5_0000_1234);
        beat();
        chk(sample_valid, 1'b1);
        chk(sample_addr, 48'hA5A5_0000_1234);
        idle();
        set(3, GOOD, 48'h0);
        beat();
        chk(sample_valid, 1'b0);
        chk(sample_addr, 48'hA5A5_0000_1234);
        idle();
        set(0, F_V, 48'h0000_BEEF_0042);
        beat();
        chk(sample_valid, 1'b1);
        chk(sample_addr, 48'h0000_BEEF_0042);
        idle();
        beat();
        chk(sample_valid, 1'b0);
    endtask

    initial begin
        idle();
        counter_sel[0] = '0;
        counter_sel[1] = '0;
        repeat (3) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk(counter_inc[0], 3'h0);
        chk(sample_addr, 48'h0);
        t_trans();
        t_alias();
        t_retire();
        t_precise();
        print_verdict();
    end
endmodule
